// ==== rtl/module_disable_ctrl.sv ====
/*
 * Peripheral module disable controller: two APB registers of disable
 * bits, per-peripheral gates, clock network gating and memory blocking.
 * Assumes an APB master on ref_clk_i and peripherals on the same clock.
 */
// Added by the designer: the APB slave port.
`timescale 1ns/1ps

`include "module_disable_defines.svh"

module module_disable_ctrl
	import module_disable_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int OUT_W = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [15:0] periph_sfr_wr_i,
	input wire logic [16*8-1:0] periph_sfr_rdata_i,
	input wire logic [16*OUT_W-1:0] periph_out_i,
	output logic [15:0] periph_rst_hold_o,
	output logic [15:0] periph_sfr_wr_o,
	output logic [16*8-1:0] periph_sfr_rdata_o,
	output logic [16*OUT_W-1:0] periph_out_o,
	output logic full_rate_clk_en_o,
	output logic quarter_rate_clk_en_o,
	input wire logic nvm_rd_req_i,
	input wire logic nvm_wr_req_i,
	input wire logic memctl_wr_i,
	output logic nvm_rd_req_o,
	output logic nvm_wr_req_o,
	output logic memctl_wr_o
);

	// ------------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CTRL0_ADDR = ADDR_W'(`MD_CTRL0_IDX << 2);
	localparam logic [ADDR_W-1:0] CTRL1_ADDR = ADDR_W'(`MD_CTRL1_IDX << 2);

	ctrl_byte_t module_disable_ctrl_0;
	ctrl_byte_t module_disable_ctrl_1;
	reg_sel_t reg_sel;
	logic access;
	logic wr_done;
	logic [15:0] disable_vec;
	logic [1:0] quarter_cnt;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	always_comb begin
		if (paddr_i == CTRL0_ADDR) begin
			reg_sel = SEL_CTRL0;
		end else if (paddr_i == CTRL1_ADDR) begin
			reg_sel = SEL_CTRL1;
		end else begin
			reg_sel = SEL_NONE;
		end
	end

	// One wait state: pready rises at the edge that ends the first access cycle
	assign access = psel_i & penable_i;
	assign wr_done = access & pready_o & pwrite_i & pstrb_i[0];

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_o <= 1'b0;
		end else begin
			pready_o <= access & ~pready_o;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pslverr_o <= 1'b0;
		end else begin
			pslverr_o <= access & ~pready_o & (reg_sel == SEL_NONE);
		end
	end

	// Read data is captured with pready so it is stable at the sampling edge
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (access & ~pready_o & ~pwrite_i) begin
			unique case (reg_sel)
				SEL_CTRL0: prdata_o <= {24'h00_0000, module_disable_ctrl_0};
				SEL_CTRL1: prdata_o <= {24'h00_0000, module_disable_ctrl_1};
				SEL_NONE: prdata_o <= 32'h0000_0000;
			endcase
		end else if (!access) begin
			prdata_o <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------------
	// Disable registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			module_disable_ctrl_0 <= `MD_CTRL0_RESET;
		end else if (wr_done && reg_sel == SEL_CTRL0) begin
			module_disable_ctrl_0 <= pwdata_i[7:0] & `MD_CTRL0_MASK;
		end
	end

	// Bit 4 is masked off by MD_CTRL1_MASK on every write; it always reads zero
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			module_disable_ctrl_1 <= `MD_CTRL1_RESET;
		end else if (wr_done && reg_sel == SEL_CTRL1) begin
			module_disable_ctrl_1 <= pwdata_i[7:0] & `MD_CTRL1_MASK;
		end
	end

	// Channel 0..7 from register 0, 8..15 from register 1; 12 never disabled
	assign disable_vec = {module_disable_ctrl_1, module_disable_ctrl_0};

	// ------------------------------------------------------------------
	// Per-peripheral gates
	// ------------------------------------------------------------------
	for (genvar ch = 0; ch < 16; ch++) begin : g_gate
		periph_gate #(
			.OUT_W(OUT_W)
		) u_gate (
			.ref_clk_i(ref_clk_i),
			.rst_b_i(rst_b_i),
			.disable_i(disable_vec[ch]),
			.sfr_wr_i(periph_sfr_wr_i[ch]),
			.sfr_rdata_i(periph_sfr_rdata_i[ch*8 +: 8]),
			.out_i(periph_out_i[ch*OUT_W +: OUT_W]),
			.rst_hold_o(periph_rst_hold_o[ch]),
			.sfr_wr_o(periph_sfr_wr_o[ch]),
			.sfr_rdata_o(periph_sfr_rdata_o[ch*8 +: 8]),
			.out_o(periph_out_o[ch*OUT_W +: OUT_W])
		);
	end

	// ------------------------------------------------------------------
	// Clock network enables
	// ------------------------------------------------------------------
	// A set bit means gated; the opposite wording in the note is ignored
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			full_rate_clk_en_o <= 1'b1;
		end else begin
			full_rate_clk_en_o <= ~module_disable_ctrl_0[`MD_PERIPH_SYSCLK_GATE_BIT];
		end
	end

	// Quarter-rate divider free-runs, independent of the gate bit
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			quarter_cnt <= 2'h0;
		end else begin
			quarter_cnt <= quarter_cnt + 2'h1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			quarter_rate_clk_en_o <= 1'b0;
		end else begin
			quarter_rate_clk_en_o <= (quarter_cnt == `MD_QUARTER_LAST);
		end
	end

	// ------------------------------------------------------------------
	// Non-volatile memory blocking
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			nvm_rd_req_o <= 1'b0;
			nvm_wr_req_o <= 1'b0;
			memctl_wr_o <= 1'b0;
		end else begin
			nvm_rd_req_o <= nvm_rd_req_i & ~module_disable_ctrl_0[`MD_NONVOLATILE_ACCESS_OFF_BIT];
			nvm_wr_req_o <= nvm_wr_req_i & ~module_disable_ctrl_0[`MD_NONVOLATILE_ACCESS_OFF_BIT];
			memctl_wr_o <= memctl_wr_i & ~module_disable_ctrl_0[`MD_NONVOLATILE_ACCESS_OFF_BIT];
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_write_ctrl0;
		wr_done && reg_sel == SEL_CTRL0;
	endsequence

	sequence s_write_ctrl1;
		wr_done && reg_sel == SEL_CTRL1;
	endsequence

	sequence s_bit_cleared(int b);
		$fell(disable_vec[b]);
	endsequence

	AST_RESET_CLEAR: assert property (
		$rose(rst_b_i) |-> (module_disable_ctrl_0 == 8'h00) && (module_disable_ctrl_1 == 8'h00)
			&& (periph_rst_hold_o == 16'h0000)
	) else $error("disable bits not clear after reset");

	AST_HOLD_FOLLOWS: assert property (
		disable_vec[0] ##1 disable_vec[0] |-> periph_rst_hold_o[0]
	) else $error("disabled peripheral not held in reset");

	AST_WRITE_BLOCKED: assert property (
		disable_vec[15] && periph_sfr_wr_i[15] |=> !periph_sfr_wr_o[15]
	) else $error("write reached a disabled peripheral");

	AST_READ_ZERO: assert property (
		disable_vec[8] |=> periph_sfr_rdata_o[8*8 +: 8] == 8'h00
	) else $error("disabled peripheral read not zero");

	AST_OUTPUT_FORCED: assert property (
		disable_vec[7] |=> periph_out_o[7*OUT_W +: OUT_W] == '0
	) else $error("disabled peripheral output active");

	AST_REENABLE: assert property (
		s_bit_cleared(3) |-> periph_rst_hold_o[3] ##1 !periph_rst_hold_o[3]
	) else $error("peripheral not released after clear");

	AST_CTRL0_WRITE: assert property (
		s_write_ctrl0 |=> module_disable_ctrl_0 == $past(pwdata_i[7:0])
	) else $error("register 0 did not take written value");

	AST_CTRL1_WRITE: assert property (
		s_write_ctrl1 |=> module_disable_ctrl_1 == ($past(pwdata_i[7:0]) & 8'hEF)
	) else $error("register 1 value or unused bit wrong");

	AST_UNUSED_ZERO: assert property (
		!module_disable_ctrl_1[`MD_CTRL1_UNUSED_BIT] && !periph_rst_hold_o[12]
	) else $error("unimplemented bit set");

	AST_SYSCLK_GATE: assert property (
		s_write_ctrl0 ##1 module_disable_ctrl_0[`MD_PERIPH_SYSCLK_GATE_BIT] |=> !full_rate_clk_en_o
	) else $error("full-rate clock not gated");

	AST_QUARTER_RUNS: assert property (
		quarter_rate_clk_en_o |-> ##4 quarter_rate_clk_en_o ##1 !quarter_rate_clk_en_o[*3]
	) else $error("quarter-rate enable disturbed");

	AST_NVM_BLOCK: assert property (
		module_disable_ctrl_0[`MD_NONVOLATILE_ACCESS_OFF_BIT] && (nvm_rd_req_i || nvm_wr_req_i || memctl_wr_i)
			|=> !nvm_rd_req_o && !nvm_wr_req_o && !memctl_wr_o
	) else $error("memory access passed while blocked");

	AST_NVM_PASS: assert property (
		!module_disable_ctrl_0[`MD_NONVOLATILE_ACCESS_OFF_BIT] && nvm_rd_req_i |=> nvm_rd_req_o
	) else $error("memory read lost while enabled");

	AST_SYNC_START: assert property (
		$rose(disable_vec[1]) |-> !periph_rst_hold_o[1] ##1 periph_rst_hold_o[1]
	) else $error("reset hold not one edge after write");

	AST_APB_WAIT: assert property (
		access && !pready_o |=> pready_o
	) else $error("pready late");

	// Pass-through and bus-side checks; a stuck gate would slip past the blocking checks alone
	AST_HOLD_ALL: assert property (
		periph_rst_hold_o == $past(disable_vec)
	) else $error("reset hold does not follow disable bits");

	AST_WRITE_PASS: assert property (
		!disable_vec[15] && periph_sfr_wr_i[15] |=> periph_sfr_wr_o[15]
	) else $error("write lost on an enabled peripheral");

	AST_READ_PASS: assert property (
		!disable_vec[8] |=> periph_sfr_rdata_o[8*8 +: 8] == $past(periph_sfr_rdata_i[8*8 +: 8])
	) else $error("enabled peripheral read data altered");

	AST_OUTPUT_PASS: assert property (
		!disable_vec[7] |=> periph_out_o[7*OUT_W +: OUT_W] == $past(periph_out_i[7*OUT_W +: OUT_W])
	) else $error("enabled peripheral output altered");

	AST_SYSCLK_OPEN: assert property (
		!module_disable_ctrl_0[`MD_PERIPH_SYSCLK_GATE_BIT] |=> full_rate_clk_en_o
	) else $error("full-rate clock gated while bit clear");

	AST_NVM_WR_PASS: assert property (
		!module_disable_ctrl_0[`MD_NONVOLATILE_ACCESS_OFF_BIT] |=> nvm_wr_req_o == $past(nvm_wr_req_i) && memctl_wr_o == $past(memctl_wr_i)
	) else $error("memory write path altered while enabled");

	AST_RESET_OUTS: assert property (
		$rose(rst_b_i) |-> full_rate_clk_en_o && !nvm_rd_req_o && !nvm_wr_req_o && !memctl_wr_o && !pready_o
	) else $error("outputs not at reset level after reset");

	AST_PREADY_PULSE: assert property (
		pready_o |=> !pready_o
	) else $error("pready longer than one cycle");

	AST_SLVERR_READY: assert property (
		pslverr_o |-> pready_o
	) else $error("slave error without pready");

	AST_RDATA_IDLE: assert property (
		!access |=> prdata_o == 32'h0000_0000
	) else $error("read data not zero while idle");

	AST_RDATA_UPPER: assert property (
		prdata_o[31:8] == 24'h00_0000
	) else $error("read data upper bits not zero");

	AST_UNMAPPED_KEEP: assert property (
		access && pready_o && reg_sel == SEL_NONE |=> $stable(module_disable_ctrl_0) && $stable(module_disable_ctrl_1)
	) else $error("unmapped access changed a register");

	AST_STROBE_KEEP: assert property (
		access && pready_o && pwrite_i && !pstrb_i[0] |=> $stable(module_disable_ctrl_0) && $stable(module_disable_ctrl_1)
	) else $error("write without strobe changed a register");

	AST_RDATA_CTRL0: assert property (
		access && !pready_o && !pwrite_i && reg_sel == SEL_CTRL0 |=> prdata_o == {24'h00_0000, $past(module_disable_ctrl_0)}
	) else $error("register 0 read data wrong");

	AST_RDATA_CTRL1: assert property (
		access && !pready_o && !pwrite_i && reg_sel == SEL_CTRL1 |=> prdata_o == {24'h00_0000, $past(module_disable_ctrl_1)}
	) else $error("register 1 read data wrong");

endmodule

// ==== rtl/module_disable_defines.svh ====
/*
 * Offsets, field positions, reset values and timing counts of the
 * peripheral module disable controller.
 * Assumes inclusion by bare name from the rtl folder; definitions only.
 */
`ifndef MODULE_DISABLE_DEFINES_SVH
`define MODULE_DISABLE_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define MD_CTRL0_IDX 12'h10C
`define MD_CTRL1_IDX 12'h10D

// ----------------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------------
`define MD_CTRL0_RESET 8'h00
`define MD_CTRL1_RESET 8'h00
`define MD_CTRL0_MASK 8'hFF
`define MD_CTRL1_MASK 8'hEF

// ----------------------------------------------------------------------
// Control register 0 fields
// ----------------------------------------------------------------------
`define MD_TIMER_ZERO_OFF_BIT 7
`define MD_CLOCK_REF_OUT_OFF_BIT 6
`define MD_PIN_CHANGE_IRQ_OFF_BIT 5
`define MD_ACTIVE_TUNING_OFF_BIT 4
`define MD_PERIPH_SYSCLK_GATE_BIT 3
`define MD_MEMORY_SCANNER_OFF_BIT 2
`define MD_CHECKSUM_UNIT_OFF_BIT 1
`define MD_NONVOLATILE_ACCESS_OFF_BIT 0

// ----------------------------------------------------------------------
// Control register 1 fields
// ----------------------------------------------------------------------
`define MD_PULSE_WIDTH_ONE_OFF_BIT 7
`define MD_CAPTURE_COMPARE_TWO_OFF_BIT 6
`define MD_CAPTURE_COMPARE_ONE_OFF_BIT 5
`define MD_CTRL1_UNUSED_BIT 4
`define MD_TIMER_FOUR_OFF_BIT 3
`define MD_TIMER_TWO_OFF_BIT 2
`define MD_TIMER_THREE_OFF_BIT 1
`define MD_TIMER_ONE_OFF_BIT 0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MD_QUARTER_DIV 4
`define MD_QUARTER_LAST 2'h3

`endif

// ==== rtl/module_disable_pkg.sv ====
/*
 * Types shared by the module disable controller files.
 * Assumes nothing of its surroundings.
 */
package module_disable_pkg;

	typedef enum {SEL_NONE, SEL_CTRL0, SEL_CTRL1} reg_sel_t;

	typedef logic [7:0] ctrl_byte_t;

endpackage

// ==== rtl/periph_gate.sv ====
/*
 * One peripheral's gate: reset hold, register access blanking and
 * output forcing, all driven by that peripheral's disable bit.
 * Assumes the peripheral's signals are on the same clock.
 */
`timescale 1ns/1ps

module periph_gate
	import module_disable_pkg::*;
#(
	parameter int OUT_W = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic disable_i,
	input wire logic sfr_wr_i,
	input wire ctrl_byte_t sfr_rdata_i,
	input wire logic [OUT_W-1:0] out_i,
	output logic rst_hold_o,
	output logic sfr_wr_o,
	output ctrl_byte_t sfr_rdata_o,
	output logic [OUT_W-1:0] out_o
);

	// Reset hold follows the bit one edge later
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_hold_o <= 1'b0;
		end else begin
			rst_hold_o <= disable_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sfr_wr_o <= 1'b0;
			sfr_rdata_o <= 8'h00;
		end else begin
			sfr_wr_o <= sfr_wr_i & ~disable_i;
			sfr_rdata_o <= disable_i ? 8'h00 : sfr_rdata_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_o <= '0;
		end else begin
			out_o <= disable_i ? '0 : out_i;
		end
	end

endmodule

// ==== test/periph_model.sv ====
/*
 * Bank of sixteen gated peripherals seen from the controller's far side.
 * Assumes the controller's per-channel reset hold lines drive it.
 */
`timescale 1ns/1ps

module periph_model #(
	parameter int OUT_W = 4
) (
	input wire logic [15:0] rst_hold_i,
	output logic [16*8-1:0] sfr_rdata_o,
	output logic [16*OUT_W-1:0] out_o
);
	// A held channel still shows nonzero values, so any blanking must come from the gate
	always_comb begin
		for (int ch = 0; ch < 16; ch++) begin
			sfr_rdata_o[ch*8+:8] = rst_hold_i[ch] ? (8'hC0 | 8'(ch)) : (8'h30 | 8'(ch));
			out_o[ch*OUT_W+:OUT_W] = OUT_W'(8 | ch);
		end
	end
endmodule

// ==== test/peripheral_module_disable_test.sv ====
/*
 * Self-checking bench of the module disable controller over APB.
 * Assumes the peripheral bank model and the design's register layout.
 */
`timescale 1ns/1ps

`include "module_disable_defines.svh"

module peripheral_module_disable_test;
	import module_disable_pkg::*;

	typedef struct {logic [11:0] a; logic [7:0] d; logic [3:0] s; logic [7:0] rd; logic err;} row_t;
	localparam logic [11:0] A0 = 12'(`MD_CTRL0_IDX * 4);
	localparam logic [11:0] A1 = 12'(`MD_CTRL1_IDX * 4);
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, fr_en, qr_en, nvm_rd, nvm_wr, memctl;
	logic [15:0] sfr_wr_in = 16'hFFFF, hold, sfr_wr_out;
	logic [127:0] rdata_in, rdata_out;
	logic [63:0] out_in, out_out;
	logic [2:0] nvm_req = 3'h7;
	int n_fail = 0;
	int tests_run = 0;
	row_t rows [8] = '{'{A0, 8'hFF, 4'hF, 8'hFF, 1'b0}, '{A1, 8'hFF, 4'hF, 8'hEF, 1'b0},
		'{A0, 8'h09, 4'hF, 8'h09, 1'b0}, '{A1, 8'h5A, 4'hF, 8'h4A, 1'b0},
		'{A0, 8'h77, 4'h0, 8'h09, 1'b0}, '{12'h438, 8'h33, 4'hF, 8'h00, 1'b1},
		'{A1, 8'h00, 4'hF, 8'h00, 1'b0}, '{A0, 8'h00, 4'hF, 8'h00, 1'b0}};

	always #12.5 ref_clk_i = ~ref_clk_i;

	periph_model u_periph_model (.rst_hold_i(hold), .sfr_rdata_o(rdata_in), .out_o(out_in));

	module_disable_ctrl u_module_disable_ctrl (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.periph_sfr_wr_i(sfr_wr_in), .periph_sfr_rdata_i(rdata_in), .periph_out_i(out_in),
		.periph_rst_hold_o(hold), .periph_sfr_wr_o(sfr_wr_out), .periph_sfr_rdata_o(rdata_out),
		.periph_out_o(out_out), .full_rate_clk_en_o(fr_en), .quarter_rate_clk_en_o(qr_en),
		.nvm_rd_req_i(nvm_req[2]), .nvm_wr_req_i(nvm_req[1]), .memctl_wr_i(nvm_req[0]),
		.nvm_rd_req_o(nvm_rd), .nvm_wr_req_o(nvm_wr), .memctl_wr_o(memctl)
	);

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task close_out;
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task check(input string what, input logic [127:0] exp, input logic [127:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] rd, output logic err);
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		// Pready is read at the rising edge; only the watchdog ends a wait
		do begin
			@(posedge ref_clk_i);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task check_outs(input ctrl_byte_t c0, input ctrl_byte_t c1);
		logic [15:0] m;
		m = {c1 & `MD_CTRL1_MASK, c0};
		check("rst_hold", m, hold);
		check("sfr_wr", 16'(~m), sfr_wr_out);
		for (int ch = 0; ch < 16; ch++) begin
			check("sfr_rdata", m[ch] ? 8'h00 : (8'h30 | 8'(ch)), rdata_out[ch*8+:8]);
			check("out", m[ch] ? 4'h0 : 4'(8 | ch), out_out[ch*4+:4]);
		end
		check("full_rate", !c0[`MD_PERIPH_SYSCLK_GATE_BIT], fr_en);
		check("nvm", {3{~c0[`MD_NONVOLATILE_ACCESS_OFF_BIT]}}, {nvm_rd, nvm_wr, memctl});
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		ctrl_byte_t c0, c1;
		logic [31:0] rd;
		logic err;
		int q;
		c0 = 8'h00;
		c1 = 8'h00;
		repeat (5) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		check_outs(8'h00, 8'h00);
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, {24'h0, rows[i].d}, rows[i].s, rd, err);
			check("write_err", rows[i].err, err);
			apb(1'b0, rows[i].a, 32'h0, 4'h0, rd, err);
			check("readback", {24'h0, rows[i].rd}, rd);
			check("read_err", rows[i].err, err);
			if (rows[i].a == A0) c0 = rows[i].rd;
			if (rows[i].a == A1) c1 = rows[i].rd;
			// Software keeps off a re-enabled peripheral for a few cycles
			repeat (3) @(posedge ref_clk_i);
			@(negedge ref_clk_i);
			check_outs(c0, c1);
		end
		// Hold rises on the edge after the storing write, not before
		apb(1'b1, A1, 32'h01, 4'hF, rd, err);
		@(negedge ref_clk_i);
		check("hold_early", 1'b0, hold[8]);
		@(negedge ref_clk_i);
		check("hold_late", 1'b1, hold[8]);
		// Quarter-rate enable keeps pulsing with the full-rate clock gated
		apb(1'b1, A0, 32'h08, 4'hF, rd, err);
		q = 0;
		repeat (16) begin
			@(negedge ref_clk_i);
			if (qr_en === 1'b1) q++;
		end
		check("quarter_pulses", 4, q);
		check_outs(8'h08, 8'h01);
		// Reset in mid-run clears everything set before it
		apb(1'b1, A0, 32'hFF, 4'hF, rd, err);
		@(posedge ref_clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		apb(1'b0, A0, 32'h0, 4'h0, rd, err);
		check("ctrl0_after_reset", 32'h0, rd);
		apb(1'b0, A1, 32'h0, 4'h0, rd, err);
		check("ctrl1_after_reset", 32'h0, rd);
		@(negedge ref_clk_i);
		check_outs(8'h00, 8'h00);
		// Memory requests pass bit for bit while access is enabled
		@(posedge ref_clk_i);
		nvm_req <= 3'h5;
		repeat (2) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		check("nvm_pass", 3'h5, {nvm_rd, nvm_wr, memctl});
		close_out;
	end

	initial begin
		#125000;
		n_fail++;
		close_out;
	end
endmodule
